// File: core/ffp_fault_ctrl.sv
// Fault supervision for a quasi-resonant flyback controller: gate drive gating,
// latch, auto-recovery and restart decisions.
// Assumes comparator flags are asynchronous levels; supply and pulse strobes are synchronous.
`timescale 1ns/100ps
`default_nettype none
module ffp_fault_ctrl #(
  parameter int OVLD_CYC = ffp_pkg::OVLD_CYC,
  parameter int AUTOREC_CYC = ffp_pkg::AUTOREC_CYC,
  parameter int SOFTSTART_CYC = ffp_pkg::SOFTSTART_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic autorec_variant,
  input wire logic supply_start,
  input wire logic supply_reset,
  input wire logic line_removal,
  input wire logic pulse_start,
  input wire logic pulse_stop,
  input wire logic fault_low_raw,
  input wire logic fault_high_raw,
  input wire logic overtemp_exit_raw,
  input wire logic overload_raw,
  input wire logic abn_oc_raw,
  input wire logic supply_ovp_raw,
  input wire logic thermal_shdn_raw,
  input wire logic demag_armed_raw,
  output logic gate_drive_output,
  output logic thermistor_bias_current_en,
  output logic valley_timeout_en,
  output logic fault_latched,
  output logic autorec_active,
  output logic nonlatch_fault,
  output logic soft_start_active,
  output logic overload_expired
);

  // ********************************
  // Local sizes
  // ********************************
  localparam int MAXON = ffp_pkg::MAX_ON_CYC;
  localparam int ONW = $clog2(ffp_pkg::MAX_ON_CYC + 1);
  localparam int BW = $clog2(ffp_pkg::FAULT_BLANK_CYC + 1);
  localparam int SW = $clog2(SOFTSTART_CYC + 1);
  localparam int AW = $clog2(AUTOREC_CYC + 1);

  // ********************************
  // Flag synchronisation
  // ********************************
  ffp_flags_if #(.N(ffp_pkg::FLG_N)) flg ();

  assign flg.raw = {demag_armed_raw, thermal_shdn_raw, supply_ovp_raw, abn_oc_raw,
                    overload_raw, overtemp_exit_raw, fault_high_raw, fault_low_raw};

  ffp_sync #(.N(ffp_pkg::FLG_N)) u_sync (
    .clock(clock),
    .rst(rst),
    .bus(flg.syncer)
  );

  logic low_s;
  logic high_s;
  logic exit_s;
  logic ovld_s;
  logic abn_s;
  logic ovp_s;
  logic thermal_s;
  logic demag_s;
  assign low_s = flg.sync[ffp_pkg::FLG_LOW];
  assign high_s = flg.sync[ffp_pkg::FLG_HIGH];
  assign exit_s = flg.sync[ffp_pkg::FLG_OT_EXIT];
  assign ovld_s = flg.sync[ffp_pkg::FLG_OVLD];
  assign abn_s = flg.sync[ffp_pkg::FLG_ABN_OC];
  assign ovp_s = flg.sync[ffp_pkg::FLG_OVP];
  assign thermal_s = flg.sync[ffp_pkg::FLG_THERMAL];
  assign demag_s = flg.sync[ffp_pkg::FLG_DEMAG];

  // ********************************
  // Declarations
  // ********************************
  ffp_pkg::ffp_state_e state_q;
  ffp_pkg::ffp_state_e state_d;
  logic bias_q;
  logic [BW-1:0] low_cnt_q;
  logic [BW-1:0] high_cnt_q;
  logic [SW-1:0] ss_cnt_q;
  logic [AW-1:0] ar_cnt_q;
  logic ar_done_q;
  logic otp_cause_q;
  logic gate_q;
  logic gate_d;
  logic [ONW-1:0] on_cnt_q;
  logic trip_q;
  logic [ffp_pkg::ABNORMAL_OVERCURRENT_FAULT_W-1:0] abnormal_overcurrent_fault_cnt_q;
  logic ovld_exp;
  logic low_cond;
  logic low_hit;
  logic high_hit;
  logic running;
  logic run_next;
  logic sensing;
  logic pulse_tripped;
  logic pulse_end;
  logic abnormal_overcurrent_fault_last;
  logic ss_done;
  logic clear_src;
  logic valley_q;
  logic latched_q;
  logic autorec_q;
  logic nonlatch_q;
  logic soft_q;

  // Persistence filter step shared by the upper and lower fault inputs
  function automatic logic [BW-1:0] blank_next(input logic cond, input logic [BW-1:0] cnt);
    logic [BW-1:0] res;
    res = cnt;
    if (!cond) begin
      res = '0;
    end else if (cnt != BW'(ffp_pkg::FAULT_BLANK_CYC)) begin
      res = cnt + 1'b1;
    end
    return res;
  endfunction : blank_next

  function automatic logic is_running(input ffp_pkg::ffp_state_e st);
    return (st == ffp_pkg::ST_SOFT) || (st == ffp_pkg::ST_RUN);
  endfunction : is_running

  assign running = is_running(state_q);
  assign run_next = is_running(state_d);
  assign clear_src = supply_reset || line_removal;
  assign ss_done = (ss_cnt_q == SW'(SOFTSTART_CYC - 1));

  // ********************************
  // Fault input qualification
  // ********************************
  // Lower comparator is meaningless until the bias settles, so soft-start masks it
  assign low_cond = low_s && bias_q && (state_q == ffp_pkg::ST_RUN);
  assign low_hit = low_cond && (low_cnt_q == BW'(ffp_pkg::FAULT_BLANK_CYC));
  assign high_hit = high_s && running && (high_cnt_q == BW'(ffp_pkg::FAULT_BLANK_CYC));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      low_cnt_q <= '0;
      high_cnt_q <= '0;
    end else begin
      low_cnt_q <= blank_next(low_cond, low_cnt_q);
      high_cnt_q <= blank_next(high_s && running, high_cnt_q);
    end
  end

  // ********************************
  // Thermistor bias
  // ********************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bias_q <= 1'b0;
    end else if (clear_src) begin
      bias_q <= 1'b0;
    end else if (supply_start) begin
      bias_q <= 1'b1;
    end
  end

  // ********************************
  // Overload timer
  // ********************************
  ffp_ovld_timer #(.DUR(OVLD_CYC)) u_ovld (
    .clock(clock),
    .rst(rst),
    .clear(!running),
    .count_up(ovld_s),
    .expired(ovld_exp)
  );

  // ********************************
  // Fault state machine
  // ********************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      ffp_pkg::ST_OFF: begin
        if (supply_start && !ovp_s && !thermal_s && !high_s) begin
          state_d = ffp_pkg::ST_SOFT;
        end
      end
      ffp_pkg::ST_SOFT, ffp_pkg::ST_RUN: begin
        if (ovp_s || high_hit || abnormal_overcurrent_fault_last) begin
          state_d = ffp_pkg::ST_LATCHED;
        end else if (thermal_s) begin
          state_d = ffp_pkg::ST_NONLATCH;
        end else if (low_hit || ovld_exp) begin
          state_d = autorec_variant ? ffp_pkg::ST_AUTOREC : ffp_pkg::ST_LATCHED;
        end else if ((state_q == ffp_pkg::ST_SOFT) && ss_done) begin
          state_d = ffp_pkg::ST_RUN;
        end
      end
      ffp_pkg::ST_LATCHED: begin
        if (clear_src) begin
          state_d = ffp_pkg::ST_OFF;
        end
      end
      ffp_pkg::ST_AUTOREC: begin
        if (clear_src) begin
          state_d = ffp_pkg::ST_OFF;
        end else if (ar_done_q && supply_start && (!otp_cause_q || exit_s) && !ovp_s && !thermal_s && !high_s) begin
          state_d = ffp_pkg::ST_SOFT;
        end
      end
      ffp_pkg::ST_NONLATCH: begin
        if (clear_src) begin
          state_d = ffp_pkg::ST_OFF;
        end else if (!thermal_s && !ovp_s && !high_s && supply_start) begin
          state_d = ffp_pkg::ST_SOFT;
        end
      end
      default: begin
        state_d = ffp_pkg::ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ffp_pkg::ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Remembers whether the auto-recovery was caused by overtemperature
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      otp_cause_q <= 1'b0;
    end else if (running && (state_d == ffp_pkg::ST_AUTOREC)) begin
      otp_cause_q <= low_hit;
    end
  end

  // ********************************
  // Soft-start and auto-recovery timers
  // ********************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ss_cnt_q <= '0;
    end else if (state_q != ffp_pkg::ST_SOFT) begin
      ss_cnt_q <= '0;
    end else if (!ss_done) begin
      ss_cnt_q <= ss_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ar_cnt_q <= '0;
      ar_done_q <= 1'b0;
    end else if (state_q != ffp_pkg::ST_AUTOREC) begin
      ar_cnt_q <= '0;
      ar_done_q <= 1'b0;
    end else if (ar_cnt_q == AW'(AUTOREC_CYC - 1)) begin
      ar_done_q <= 1'b1;
    end else begin
      ar_cnt_q <= ar_cnt_q + 1'b1;
    end
  end

  // ********************************
  // Gate drive
  // ********************************
  // Killing the drive from state_d saves a cycle on overvoltage
  always_comb begin
    gate_d = gate_q;
    if (!run_next) begin
      gate_d = 1'b0;
    end else if (gate_q) begin
      if (pulse_stop || (on_cnt_q == ONW'(ffp_pkg::MAX_ON_CYC - 1))) begin
        gate_d = 1'b0;
      end
    end else if (pulse_start && !demag_s) begin
      gate_d = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gate_q <= 1'b0;
      on_cnt_q <= '0;
    end else begin
      gate_q <= gate_d;
      on_cnt_q <= gate_d ? (gate_q ? on_cnt_q + 1'b1 : '0) : '0;
    end
  end

  // ********************************
  // Abnormal overcurrent
  // ********************************
  assign sensing = gate_q && (on_cnt_q >= ONW'(ffp_pkg::SHORT_BLANK_CYC));
  assign pulse_tripped = trip_q || (sensing && abn_s);
  assign pulse_end = gate_q && !gate_d;
  assign abnormal_overcurrent_fault_last = pulse_end && pulse_tripped
                     && (abnormal_overcurrent_fault_cnt_q == ffp_pkg::ABNORMAL_OVERCURRENT_FAULT_W'(ffp_pkg::ABNORMAL_OVERCURRENT_FAULT_LIMIT - 1));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      trip_q <= 1'b0;
    end else if (!gate_q) begin
      trip_q <= 1'b0;
    end else if (sensing && abn_s) begin
      trip_q <= 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      abnormal_overcurrent_fault_cnt_q <= '0;
    end else if (state_q == ffp_pkg::ST_OFF) begin
      abnormal_overcurrent_fault_cnt_q <= '0;
    end else if (pulse_end) begin
      if (!pulse_tripped) begin
        abnormal_overcurrent_fault_cnt_q <= '0;
      end else if (!abnormal_overcurrent_fault_last) begin
        abnormal_overcurrent_fault_cnt_q <= abnormal_overcurrent_fault_cnt_q + 1'b1;
      end
    end
  end

  // ********************************
  // Status flops
  // ********************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      valley_q <= 1'b0;
      latched_q <= 1'b0;
      autorec_q <= 1'b0;
      nonlatch_q <= 1'b0;
      soft_q <= 1'b0;
    end else begin
      valley_q <= running && !demag_s;
      latched_q <= (state_d == ffp_pkg::ST_LATCHED);
      autorec_q <= (state_d == ffp_pkg::ST_AUTOREC);
      nonlatch_q <= (state_d == ffp_pkg::ST_NONLATCH);
      soft_q <= (state_d == ffp_pkg::ST_SOFT);
    end
  end

  assign gate_drive_output = gate_q;
  assign thermistor_bias_current_en = bias_q;
  assign valley_timeout_en = valley_q;
  assign fault_latched = latched_q;
  assign autorec_active = autorec_q;
  assign nonlatch_fault = nonlatch_q;
  assign soft_start_active = soft_q;
  assign overload_expired = ovld_exp;

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_bias_waits;
    !bias_q && !supply_start |=> !bias_q;
  endproperty
  a_bias_waits: assert property (p_bias_waits) else $error("Bias enabled without supply start");

  property p_soft_masks_low;
    (state_q == ffp_pkg::ST_SOFT) |-> (low_cnt_q == '0) && !low_hit;
  endproperty
  a_soft_masks_low: assert property (p_soft_masks_low) else $error("Low fault seen in soft-start");

  property p_ovp_cuts;
    running && ovp_s |=> !gate_q && latched_q && (state_q == ffp_pkg::ST_LATCHED);
  endproperty
  a_ovp_cuts: assert property (p_ovp_cuts) else $error("Overvoltage did not cut drive and latch");

  property p_max_on;
    $rose(gate_q) |-> ##[1:MAXON] !gate_q;
  endproperty
  a_max_on: assert property (p_max_on) else $error("Drive pulse exceeded maximum on-time");

  sequence s_blank_window;
    !trip_q [*4];
  endsequence
  property p_short_blank;
    $rose(gate_q) |-> s_blank_window;
  endproperty
  a_short_blank: assert property (p_short_blank) else $error("Abnormal current sensed inside blanking");

  property p_clean_pulse_clears;
    pulse_end && !pulse_tripped && (state_q != ffp_pkg::ST_OFF) |=> (abnormal_overcurrent_fault_cnt_q == '0);
  endproperty
  a_clean_pulse_clears: assert property (p_clean_pulse_clears) else $error("Clean pulse kept ABNORMAL_OVERCURRENT_FAULT count");

  sequence s_fourth_trip;
    pulse_end && pulse_tripped && (abnormal_overcurrent_fault_cnt_q == ffp_pkg::ABNORMAL_OVERCURRENT_FAULT_W'(ffp_pkg::ABNORMAL_OVERCURRENT_FAULT_LIMIT - 1));
  endsequence
  property p_abnormal_overcurrent_fault_latch;
    s_fourth_trip |=> latched_q && !gate_q;
  endproperty
  a_abnormal_overcurrent_fault_latch: assert property (p_abnormal_overcurrent_fault_latch) else $error("Fourth abnormal pulse did not latch");

  property p_latch_holds;
    latched_q && !clear_src |=> latched_q;
  endproperty
  a_latch_holds: assert property (p_latch_holds) else $error("Latched fault left without clear");

  property p_thermal_holds;
    (state_q == ffp_pkg::ST_NONLATCH) && thermal_s && !clear_src |=> nonlatch_q && !gate_q;
  endproperty
  a_thermal_holds: assert property (p_thermal_holds) else $error("Restart while thermal flag set");

  property p_thermal_clear;
    (state_q == ffp_pkg::ST_NONLATCH) && clear_src |=> (state_q == ffp_pkg::ST_OFF);
  endproperty
  a_thermal_clear: assert property (p_thermal_clear) else $error("Thermal fault not cleared");

  property p_autorec_restart;
    (state_q == ffp_pkg::ST_AUTOREC) && (state_d == ffp_pkg::ST_SOFT)
      |-> ar_done_q && supply_start && (!otp_cause_q || exit_s);
  endproperty
  a_autorec_restart: assert property (p_autorec_restart) else $error("Early auto-recovery restart");

endmodule : ffp_fault_ctrl
`default_nettype wire

// File: core/ffp_ovld_timer.sv
// Integrating overload timer: counts up with the fault, down without it.
// Assumes clear is held while the controller is not switching.
`timescale 1ns/100ps
`default_nettype none
module ffp_ovld_timer #(
  parameter int DUR = ffp_pkg::OVLD_CYC,
  parameter int W = $clog2(DUR + 1)
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clear,
  input wire logic count_up,
  output logic expired
);

  logic [W-1:0] cnt_q;
  logic exp_q;

  // Saturates at both ends so a long fault never wraps to a short count
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (clear) begin
      cnt_q <= '0;
    end else if (count_up) begin
      if (cnt_q != W'(DUR)) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      exp_q <= 1'b0;
    end else begin
      exp_q <= !clear && (cnt_q == W'(DUR));
    end
  end

  assign expired = exp_q;

  property p_no_wrap_low;
    @(posedge clock) disable iff (rst) (cnt_q == '0) && !count_up |=> (cnt_q == '0);
  endproperty
  a_no_wrap_low: assert property (p_no_wrap_low) else $error("Overload timer wrapped below zero");

  property p_no_wrap_high;
    @(posedge clock) disable iff (rst) (cnt_q == W'(DUR)) && count_up && !clear |=> (cnt_q == W'(DUR)) && exp_q;
  endproperty
  a_no_wrap_high: assert property (p_no_wrap_high) else $error("Overload timer left its ceiling");

endmodule : ffp_ovld_timer
`default_nettype wire

// File: core/ffp_sync.sv
// Two-stage synchroniser for the comparator flags.
// Assumes flags are slow levels; pulses shorter than one clock may be missed.
`timescale 1ns/100ps
`default_nettype none
module ffp_sync #(
  parameter int N = ffp_pkg::FLG_N
) (
  input wire logic clock,
  input wire logic rst,
  ffp_flags_if.syncer bus
);

  logic [N-1:0] meta_q;
  logic [N-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= bus.raw;
      sync_q <= meta_q;
    end
  end

  assign bus.sync = sync_q;

  property p_two_stage;
    @(posedge clock) disable iff (rst) ##2 (sync_q == $past(bus.raw, 2));
  endproperty
  a_two_stage: assert property (p_two_stage) else $error("Flag sync latency is not two cycles");

endmodule : ffp_sync
`default_nettype wire

// File: pkg/ffp_flags_if.sv
// Bundle of raw and synchronised comparator flags.
// Assumes the raw side is asynchronous to the logic clock.
`timescale 1ns/100ps
`default_nettype none
interface ffp_flags_if #(parameter int N = ffp_pkg::FLG_N);
  logic [N-1:0] raw;
  logic [N-1:0] sync;
  modport syncer (input raw, output sync);
  modport user (output raw, input sync);
endinterface : ffp_flags_if
`default_nettype wire

// File: pkg/ffp_pkg.sv
// Constants, timing counts, flag indices and state type for the flyback fault logic.
// Assumes a single 20 MHz system clock; all times become cycle counts here.
package ffp_pkg;

  // ********************************
  // Clock and timing
  // ********************************
  localparam int CLK_PERIOD_NS = 50;
  // Least time, rounded up to whole cycles
  localparam int SHORT_BLANK_NS = 125;
  localparam int SHORT_BLANK_CYC = (SHORT_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest time, rounded down
  localparam int MAX_ON_US = 32;
  localparam int MAX_ON_CYC = (MAX_ON_US * 1000) / CLK_PERIOD_NS;
  // Fault input must persist longer than this
  localparam int FAULT_BLANK_US = 30;
  localparam int FAULT_BLANK_CYC = (FAULT_BLANK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OVLD_MS = 160;
  localparam int OVLD_CYC = (OVLD_MS * 1000000) / CLK_PERIOD_NS;
  localparam int AUTOREC_MS = 1200;
  localparam int AUTOREC_CYC = (AUTOREC_MS * 1000000) / CLK_PERIOD_NS;
  // Soft-start length has no fixed figure here; plain default
  localparam int SOFTSTART_CYC = 1024;

  // ********************************
  // Abnormal overcurrent
  // ********************************
  localparam int ABNORMAL_OVERCURRENT_FAULT_LIMIT = 4;
  localparam int ABNORMAL_OVERCURRENT_FAULT_W = 3;

  // ********************************
  // Comparator flag positions
  // ********************************
  localparam int FLG_LOW = 0;
  localparam int FLG_HIGH = 1;
  localparam int FLG_OT_EXIT = 2;
  localparam int FLG_OVLD = 3;
  localparam int FLG_ABN_OC = 4;
  localparam int FLG_OVP = 5;
  localparam int FLG_THERMAL = 6;
  localparam int FLG_DEMAG = 7;
  localparam int FLG_N = 8;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_SOFT,
    ST_RUN,
    ST_LATCHED,
    ST_AUTOREC,
    ST_NONLATCH
  } ffp_state_e;

endpackage : ffp_pkg

// File: sim/ffp_partner.sv
// Partner model: power switch and sense network beside the fault logic.
// Assumes the gate drive is a registered level in the logic clock domain.
`timescale 1ns/100ps
`default_nettype none
module ffp_partner (
  input wire logic clock,
  input wire logic rst,
  input wire logic gate_drive_output,
  input wire logic short_winding,
  output logic abn_oc_raw,
  output logic demag_armed_raw
);
  logic [2:0] ring_q;
  // Shorted winding: sense jumps past the abnormal threshold while on
  always_ff @(posedge clock or posedge rst) begin
    if (rst) abn_oc_raw <= 1'b0;
    else abn_oc_raw <= gate_drive_output & short_winding;
  end
  // Leakage ringing keeps demag armed a while after turn-off
  always_ff @(posedge clock or posedge rst) begin
    if (rst) ring_q <= 3'h0;
    else ring_q <= gate_drive_output ? 3'h6 : ring_q - {2'h0, ring_q != 3'h0};
  end
  assign demag_armed_raw = gate_drive_output | (ring_q != 3'h0);
endmodule : ffp_partner
`default_nettype wire

// File: sim/tb.sv
// Testbench for the flyback fault logic: one task per scenario, self-checking.
// Assumes short timer parameters so the run stays a few thousand cycles.
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int SOFT = 20;
  localparam int OVLD = 50;
  localparam int AREC = 100;
  logic clock, rst, autorec_variant, fault_low_raw, fault_high_raw, overtemp_exit_raw;
  logic overload_raw, abn_oc_raw, supply_ovp_raw, thermal_shdn_raw, demag_armed_raw;
  logic gate_drive_output, thermistor_bias_current_en, valley_timeout_en, fault_latched;
  logic autorec_active, nonlatch_fault, soft_start_active, overload_expired, short_winding;
  logic [4:0] stb;
  wire logic supply_start = stb[0];
  wire logic supply_reset = stb[1];
  wire logic line_removal = stb[2];
  wire logic pulse_start = stb[3];
  wire logic pulse_stop = stb[4];
  int n_errors = 0;
  int samples_checked = 0;

  ffp_fault_ctrl #(.OVLD_CYC(OVLD), .AUTOREC_CYC(AREC), .SOFTSTART_CYC(SOFT)) dut (
    .clock, .rst, .autorec_variant, .supply_start, .supply_reset, .line_removal, .pulse_start,
    .pulse_stop, .fault_low_raw, .fault_high_raw, .overtemp_exit_raw, .overload_raw, .abn_oc_raw,
    .supply_ovp_raw, .thermal_shdn_raw, .demag_armed_raw, .gate_drive_output,
    .thermistor_bias_current_en, .valley_timeout_en, .fault_latched, .autorec_active,
    .nonlatch_fault, .soft_start_active, .overload_expired);
  ffp_partner partner (.clock, .rst, .gate_drive_output, .short_winding, .abn_oc_raw, .demag_armed_raw);

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ****************
  // Shared tasks
  // ****************
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // Strobes start on an edge so a check's #1 never shifts the drive
  task automatic strobe(input int i);
    tick(1);
    stb[i] <= 1'b1;
    tick(1);
    stb[i] <= 1'b0;
  endtask : strobe

  task automatic wait_gate(input logic lvl, output int n);
    n = 0;
    // Step off the edge so an output launched there is already settled
    #1;
    while (gate_drive_output !== lvl && n < 1000) begin
      tick(1);
      #1 n++;
    end
    if (n >= 1000) begin
      n_errors++;
      report_and_stop;
    end
  endtask : wait_gate

  task automatic do_reset(input logic v);
    tick(1);
    rst <= 1'b1;
    autorec_variant <= v;
    tick(11);
    #1 chk("bias in reset", 0, thermistor_bias_current_en);
    tick(1);
    rst <= 1'b0;
    tick(2);
    #1 chk("bias before start", 0, thermistor_bias_current_en);
  endtask : do_reset

  task automatic run_up;
    strobe(0);
    tick(1);
    #1 chk("bias at start", 1, thermistor_bias_current_en);
    chk("soft start", 1, soft_start_active);
    tick(SOFT + 2);
    #1 chk("soft start over", 0, soft_start_active);
  endtask : run_up

  task automatic pulse(input int len);
    strobe(3);
    tick(len);
    strobe(4);
    tick(12);
  endtask : pulse

  // ****************
  // Scenarios
  // ****************
  task automatic sc_max_on;
    int n;
    strobe(3);
    wait_gate(1'b1, n);
    wait_gate(1'b0, n);
    chk("on-time cycles", ffp_pkg::MAX_ON_CYC, n);
    strobe(3);
    #1 chk("pulse while armed", 0, gate_drive_output);
    chk("valley timeout while armed", 0, valley_timeout_en);
    tick(12);
    #1 chk("valley timeout after demag", 1, valley_timeout_en);
  endtask : sc_max_on

  task automatic sc_abnormal_overcurrent_fault;
    tick(1);
    short_winding <= 1'b1;
    repeat (3) pulse(10);
    short_winding <= 1'b0;
    pulse(10);
    short_winding <= 1'b1;
    repeat (3) pulse(10);
    #1 chk("trips after clean pulse", 0, fault_latched);
    pulse(10);
    #1 chk("fourth trip", 1, fault_latched);
    short_winding <= 1'b0;
    strobe(0);
    tick(2);
    #1 chk("start ignored latched", 0, soft_start_active);
    strobe(2);
    tick(1);
    #1 chk("line removal clears", 0, fault_latched);
  endtask : sc_abnormal_overcurrent_fault

  task automatic sc_ovp;
    int n;
    run_up;
    strobe(3);
    wait_gate(1'b1, n);
    tick(1);
    supply_ovp_raw <= 1'b1;
    wait_gate(1'b0, n);
    chk("ovp cut within 3", 1, n <= 3);
    chk("ovp latches", 1, fault_latched);
    tick(1);
    supply_ovp_raw <= 1'b0;
    strobe(1);
    tick(1);
    #1 chk("supply reset clears", 0, fault_latched);
  endtask : sc_ovp

  task automatic sc_thermal;
    run_up;
    tick(1);
    thermal_shdn_raw <= 1'b1;
    tick(4);
    #1 chk("thermal non-latching", 1, nonlatch_fault);
    strobe(0);
    tick(2);
    #1 chk("start while hot", 0, soft_start_active);
    tick(1);
    thermal_shdn_raw <= 1'b0;
    tick(4);
    run_up;
    tick(1);
    thermal_shdn_raw <= 1'b1;
    tick(4);
    strobe(2);
    tick(1);
    #1 chk("line removal clears thermal", 0, nonlatch_fault);
    thermal_shdn_raw <= 1'b0;
  endtask : sc_thermal

  // Low input already set at start: only the run phase may count it
  task automatic sc_low;
    tick(1);
    fault_low_raw <= 1'b1;
    tick(4);
    run_up;
    tick(597);
    #1 chk("low fault masked in soft-start", 0, fault_latched);
    tick(1);
    #1 chk("overtemp latches", 1, fault_latched);
    tick(1);
    fault_low_raw <= 1'b0;
    strobe(1);
  endtask : sc_low

  task automatic sc_overload;
    run_up;
    tick(1);
    overload_raw <= 1'b1;
    tick(40);
    overload_raw <= 1'b0;
    tick(20);
    overload_raw <= 1'b1;
    tick(20);
    #1 chk("timer counted down", 0, autorec_active);
    tick(13);
    #1 chk("overload timer full", 1, overload_expired);
    tick(7);
    #1 chk("overload expiry", 1, autorec_active);
    chk("expiry clears out of run", 0, overload_expired);
    chk("gate off in recovery", 0, gate_drive_output);
    overload_raw <= 1'b0;
    strobe(0);
    tick(2);
    #1 chk("start before timer", 0, soft_start_active);
    tick(AREC);
    run_up;
  endtask : sc_overload

  // Overtemperature in the recovery variant also needs the exit flag
  task automatic sc_otp_recover;
    tick(1);
    fault_low_raw <= 1'b1;
    tick(602);
    #1 chk("overtemp blanked", 0, autorec_active);
    tick(1);
    #1 chk("overtemp recovery", 1, autorec_active);
    fault_low_raw <= 1'b0;
    tick(AREC + 2);
    strobe(0);
    tick(2);
    #1 chk("start before exit", 0, soft_start_active);
    overtemp_exit_raw <= 1'b1;
    tick(4);
    run_up;
    overtemp_exit_raw <= 1'b0;
    fault_high_raw <= 1'b1;
    tick(602);
    #1 chk("upper fault blanked", 0, fault_latched);
    tick(1);
    #1 chk("upper fault latches", 1, fault_latched);
  endtask : sc_otp_recover

  initial begin
    rst = 1'b1;
    {stb, autorec_variant, fault_low_raw, fault_high_raw, overtemp_exit_raw} = '0;
    {overload_raw, supply_ovp_raw, thermal_shdn_raw, short_winding} = '0;
    do_reset(1'b0);
    run_up;
    sc_max_on;
    sc_abnormal_overcurrent_fault;
    sc_ovp;
    sc_thermal;
    sc_low;
    do_reset(1'b1);
    sc_overload;
    sc_otp_recover;
    report_and_stop;
  end
endmodule : tb
`default_nettype wire
